// >>> testbench/msd_decoder_bench.sv
// msd_decoder_bench: random and corner tests of the decoder.
// assumes msd_pkg, msd_decoder, msd_props and msd_sfr_model compiled.
`timescale 1ns/1ps
module msd_decoder_bench;
    localparam logic [15:0] RAM_END = 16'h0e00;
    logic clk_i, reset_n_i, pc_step_i, pc_load_i, sfr_hit_i, addr_trap_o;
    logic [23:0] pc_target_i, pc_o, prog_word_i, t, pcx, pw;
    logic [15:0] sfr_rdata_i, psv_rdata_i, ea, rv, ld;
    logic [15:0] mem [0:767];
    logic s, l, b;
    int i, k, fails = 0, n_compared = 0;
    logic [23:0] pa [14] = '{24'h000000, 24'h000002, 24'h000003,
        24'h000004, 24'h0000ff, 24'h000100, 24'h000104, 24'h0001ff,
        24'h000200, 24'h7ffdfe, 24'h7ffe00, 24'h7ffe01, 24'h7fffff,
        24'hf80002};
    msd_pkg::msd_prog_req_type prog_req_i, pr;
    msd_pkg::msd_prog_map_type prog_map_o, pm;
    msd_pkg::msd_data_req_type rd_req_i, wr_req_i;
    msd_pkg::msd_lookup_type sfr_rd_o, psv_rd_o, direct_ea_o;
    msd_pkg::msd_sfr_wr_type sfr_wr_o;
    msd_pkg::msd_word_type rd_o, wreg_o;
    msd_pkg::msd_wreg_req_type wreg_req_i;
    msd_pkg::msd_direct_req_type direct_req_i;

    msd_decoder #(.RAM_WORDS(768)) msd_decoder_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .pc_step_i(pc_step_i),
        .pc_load_i(pc_load_i), .pc_target_i(pc_target_i), .pc_o(pc_o),
        .prog_req_i(prog_req_i), .prog_word_i(prog_word_i),
        .prog_map_o(prog_map_o), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i),
        .sfr_rdata_i(sfr_rdata_i), .sfr_hit_i(sfr_hit_i),
        .psv_rdata_i(psv_rdata_i), .sfr_rd_o(sfr_rd_o),
        .psv_rd_o(psv_rd_o), .sfr_wr_o(sfr_wr_o), .rd_o(rd_o),
        .addr_trap_o(addr_trap_o), .wreg_req_i(wreg_req_i),
        .wreg_o(wreg_o), .direct_req_i(direct_req_i),
        .direct_ea_o(direct_ea_o));
    msd_sfr_model msd_sfr_model_i (.sfr_rd_i(sfr_rd_o),
        .psv_rd_i(psv_rd_o), .sfr_rdata_o(sfr_rdata_i),
        .sfr_hit_o(sfr_hit_i), .psv_rdata_o(psv_rdata_i));

    // ==========================================================
    // checking and expectations
    task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    function automatic logic [15:0] exp_rd(logic [15:0] a, logic by);
        logic [15:0] w, v;
        w = {a[15:1], 1'b0};
        if (a[15]) v = w ^ 16'h9696;
        else if (w < 16'h0040) v = w ^ 16'hc3c3;
        else if (w < msd_pkg::RAM_BASE || w >= RAM_END) v = 16'h0000;
        else v = mem[(w - msd_pkg::RAM_BASE) >> 1];
        if (by) v = {8'h00, a[0] ? v[15:8] : v[7:0]};
        return v;
    endfunction : exp_rd

    function automatic msd_pkg::msd_prog_map_type exp_map(
        msd_pkg::msd_prog_req_type r, logic [23:0] wd);
        msd_pkg::msd_prog_map_type m;
        m = '0;
        m.valid = 1'b1;
        m.upper_word = r.addr[0];
        m.vector = r.addr < 24'h000200;
        m.ivt_primary = r.addr >= 24'h000004 && r.addr <= 24'h0000ff;
        m.ivt_alternate = r.addr >= 24'h000104 && r.addr <= 24'h0001ff;
        m.eeprom = r.addr >= 24'h7ffe00 && r.addr <= 24'h7fffff;
        m.eeprom_index = m.eeprom ? r.addr[8:1] : 8'h00;
        for (int j = 0; j < 8; j++) begin
            m.cfg_sel[j] = r.addr == msd_pkg::CFG_ADDRS[j*24 +: 24];
        end
        m.rdata = r.addr[0] ? {8'h00, wd[23:16]} : wd[15:0];
        m.wr_lanes = !r.write ? 3'h0 : r.addr[0] ? 3'h4 : 3'h3;
        return m;
    endfunction : exp_map

    function automatic logic [15:0] exp_w(int op, logic by,
        logic [15:0] r, logic [15:0] d);
        case (op)
            1: return r + (by ? 16'h0001 : 16'h0002);
            2: return {r[15:8], d[7:0]};
            3: return {8'h00, r[7:0]};
            default: return {{8{r[7]}}, r[7:0]};
        endcase
    endfunction : exp_w

    // ==========================================================
    // bus cycles, entered and left at the falling edge
    task automatic rd(logic [15:0] a, logic by);
        rd_req_i <= '{1'b1, by, a, 16'h0000};
        @(negedge clk_i);
        rd_req_i.valid <= 1'b0;
        chk("trap", addr_trap_o, !by && a[0]);
        @(negedge clk_i);
        chk("rd", {rd_o.valid, rd_o.data}, {1'b1, exp_rd(a, by)});
    endtask : rd

    task automatic wr(logic [15:0] a, logic by, logic [15:0] d);
        logic mis;
        logic [15:0] w;
        int x;
        mis = !by && a[0];
        w = {a[15:1], 1'b0};
        x = (w - msd_pkg::RAM_BASE) >> 1;
        wr_req_i <= '{1'b1, by, a, d};
        if (!mis && w >= msd_pkg::RAM_BASE && w < RAM_END) begin
            if (!by) mem[x] = d;
            else if (a[0]) mem[x][15:8] = d[7:0];
            else mem[x][7:0] = d[7:0];
        end
        @(negedge clk_i);
        wr_req_i.valid <= 1'b0;
        chk("wtrap", addr_trap_o, mis);
        chk("swr", sfr_wr_o.valid, w < msd_pkg::RAM_BASE && !mis);
        if (sfr_wr_o.valid === 1'b1) begin
            chk("lane", {sfr_wr_o.lane_hi, sfr_wr_o.lane_lo},
                by ? {a[0], !a[0]} : 2'b11);
            chk("swd", {sfr_wr_o.ea, sfr_wr_o.data},
                {w, by ? {2{d[7:0]}} : d});
        end
        @(negedge clk_i);
    endtask : wr

    // ==========================================================
    // clock, watchdog, main sequence
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        conclude();
    end

    initial begin
        void'($urandom(32'hbbfd3253));
        {reset_n_i, pc_step_i, pc_load_i, pc_target_i, prog_word_i} = '0;
        {prog_req_i, rd_req_i, wr_req_i, wreg_req_i, direct_req_i} = '0;
        repeat (10) @(negedge clk_i);
        reset_n_i = 1'b1;
        pcx = 24'h000000;
        chk("pc reset", pc_o, pcx);
        for (i = 0; i < 40; i++) begin
            s = 1'($urandom);
            l = (i % 7 == 3);
            t = 24'($urandom);
            pc_step_i <= s;
            pc_load_i <= l;
            pc_target_i <= t;
            @(negedge clk_i);
            pcx = l ? {t[23:1], 1'b0} : s ? pcx + 24'h000002 : pcx;
            chk("pc", pc_o, pcx);
        end
        {pc_step_i, pc_load_i} <= 2'b00;
        for (i = 0; i < 22; i++) begin
            t = i < 14 ? pa[i] : msd_pkg::CFG_ADDRS[(i - 14)*24 +: 24];
            pr = '{1'b1, 1'($urandom), t, 16'($urandom)};
            pw = 24'($urandom);
            prog_req_i <= pr;
            prog_word_i <= pw;
            @(negedge clk_i);
            pm = prog_map_o;
            if (pm.eeprom !== 1'b1) pm.eeprom_index = 8'h00;
            chk("map", pm, exp_map(pr, pw));
        end
        prog_req_i.valid <= 1'b0;
        for (i = 0; i < 768; i++) begin
            wr(16'(msd_pkg::RAM_BASE + 2 * i), 1'b0, 16'($urandom));
        end
        wr(16'h0805, 1'b0, 16'h5555);
        rd(16'h0804, 1'b0);
        rd(16'h0803, 1'b0);
        rd(16'h0dff, 1'b1);
        rd(16'h8001, 1'b1);
        for (i = 0; i < 300; i++) begin
            case ($urandom_range(3, 0))
                0: ea = 16'(msd_pkg::RAM_BASE + $urandom_range(1535, 0));
                1: ea = 16'($urandom_range(255, 0));
                2: ea = 16'($urandom);
                default: ea = 16'(16'h0dfc + $urandom_range(5, 0));
            endcase
            b = 1'($urandom);
            if ($urandom_range(1, 0) == 1) wr(ea, b, 16'($urandom));
            else rd(ea, b);
        end
        for (i = 0; i < 16; i++) begin
            k = i % 4 + 1;
            b = i[2];
            rv = i < 4 ? 16'hff80 : 16'($urandom);
            ld = 16'($urandom);
            wreg_req_i <= '{msd_pkg::msd_wop_type'(k), b, rv, ld};
            @(negedge clk_i);
            chk("wreg", wreg_o, {1'b1, exp_w(k, b, rv, ld)});
        end
        wreg_req_i.op <= msd_pkg::WOP_NONE;
        for (i = 0; i < 12; i++) begin
            b = i[0];
            rv = 16'($urandom);
            direct_req_i <= '{1'b1, b, rv};
            @(negedge clk_i);
            chk("dir", direct_ea_o, {1'b1, b ? rv : rv & 16'h1fff});
        end
        direct_req_i.valid <= 1'b0;
        conclude();
    end
endmodule : msd_decoder_bench

// >>> testbench/msd_props.sv
// msd_props: port assertions for the memory space decoder.
// assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module msd_props (
    input wire logic                        clk_i,
    input wire logic                        reset_n_i,
    input wire logic                        pc_step_i,
    input wire logic                        pc_load_i,
    input wire logic [23:0]                 pc_o,
    input wire msd_pkg::msd_prog_req_type   prog_req_i,
    input wire msd_pkg::msd_prog_map_type   prog_map_o,
    input wire msd_pkg::msd_data_req_type   rd_req_i,
    input wire msd_pkg::msd_data_req_type   wr_req_i,
    input wire msd_pkg::msd_word_type       rd_o,
    input wire logic                        addr_trap_o,
    input wire msd_pkg::msd_sfr_wr_type     sfr_wr_o,
    input wire msd_pkg::msd_wreg_req_type   wreg_req_i,
    input wire msd_pkg::msd_word_type       wreg_o,
    input wire msd_pkg::msd_direct_req_type direct_req_i,
    input wire msd_pkg::msd_lookup_type     direct_ea_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // ==========================================================
    // helpers
    wire mis_rd = rd_req_i.valid & ~rd_req_i.byte_op & rd_req_i.ea[0];
    wire mis_wr = wr_req_i.valid & ~wr_req_i.byte_op & wr_req_i.ea[0];
    wire sfr_bw = wr_req_i.valid & wr_req_i.byte_op
        & (wr_req_i.ea < msd_pkg::RAM_BASE);
    // ==========================================================
    // assertions
    pc_even_a: assert property (pc_o[0] == 1'b0)
        else $error("pc left word alignment");
    pc_step_a: assert property (pc_step_i && !pc_load_i |=>
        pc_o == $past(pc_o) + 24'h000002) else $error("pc step wrong");
    trap_rd_a: assert property (mis_rd |=> addr_trap_o)
        else $error("odd word read not trapped");
    trap_cause_a: assert property (
        addr_trap_o |-> $past(mis_rd | mis_wr)) else $error("stray trap");
    wr_drop_a: assert property (mis_wr |=> !sfr_wr_o.valid)
        else $error("odd word write not suppressed");
    wr_psv_a: assert property (wr_req_i.valid && wr_req_i.ea[15]
        |=> !sfr_wr_o.valid) else $error("window write reached sfr");
    byte_lane_a: assert property (sfr_bw |=> sfr_wr_o.valid
        && sfr_wr_o.lane_hi == $past(wr_req_i.ea[0])
        && sfr_wr_o.lane_lo == !$past(wr_req_i.ea[0]))
        else $error("byte lane strobe wrong");
    rd_lat_a: assert property (rd_req_i.valid |-> ##2 rd_o.valid)
        else $error("read answer missing");
    rd_byte_a: assert property (rd_req_i.valid && rd_req_i.byte_op
        |-> ##2 rd_o.data[15:8] == 8'h00) else $error("byte read high");
    direct_mask_a: assert property (
        direct_req_i.valid && !direct_req_i.mov_form |=>
        direct_ea_o.ea == ($past(direct_req_i.field) & 16'h1fff))
        else $error("direct field not 13 bits");
    byte_load_a: assert property (
        wreg_req_i.op == msd_pkg::WOP_BYTE_LOAD |=>
        wreg_o.data[15:8] == $past(wreg_req_i.reg_value[15:8]))
        else $error("byte load touched high byte");
    upper_zero_a: assert property (
        prog_req_i.valid && prog_req_i.addr[0] |=>
        prog_map_o.rdata[15:8] == 8'h00) else $error("phantom byte set");
    cover property (mis_wr);
    cover property (sfr_bw);
    cover property (rd_req_i.valid && rd_req_i.ea[15]);
endmodule : msd_props

bind msd_decoder msd_props msd_props_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .pc_step_i(pc_step_i),
    .pc_load_i(pc_load_i), .pc_o(pc_o), .prog_req_i(prog_req_i),
    .prog_map_o(prog_map_o), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i),
    .rd_o(rd_o), .addr_trap_o(addr_trap_o), .sfr_wr_o(sfr_wr_o),
    .wreg_req_i(wreg_req_i), .wreg_o(wreg_o),
    .direct_req_i(direct_req_i), .direct_ea_o(direct_ea_o)
);

// >>> testbench/msd_sfr_model.sv
// msd_sfr_model: register file and program window answering lookups.
// assumes lookups are answered in the cycle they are presented.
`timescale 1ns/1ps
module msd_sfr_model (
    input  wire msd_pkg::msd_lookup_type sfr_rd_i,
    input  wire msd_pkg::msd_lookup_type psv_rd_i,
    output      logic [15:0]             sfr_rdata_o,
    output      logic                    sfr_hit_o,
    output      logic [15:0]             psv_rdata_o
);
    // ==========================================================
    // only 0000..003f implemented; the rest of the area is unused
    always_comb begin
        sfr_hit_o   = sfr_rd_i.valid && sfr_rd_i.ea < 16'h0040;
        // idle lines show garbage so stale data cannot pass
        sfr_rdata_o = sfr_hit_o ? sfr_rd_i.ea ^ 16'hc3c3 : ~sfr_rd_i.ea;
        psv_rdata_o = psv_rd_i.valid ? psv_rd_i.ea ^ 16'h9696
                                     : ~psv_rd_i.ea;
    end
endmodule : msd_sfr_model

// >>> verilog/msd_decoder.sv
// msd_decoder: program and data space address decode for the core.
// assumes all request inputs come from core logic on clk_i, and that
// the special function registers and program space window answer
// their lookups combinationally in the cycle they are presented.
`timescale 1ns/1ps

module msd_decoder #(
    parameter int RAM_WORDS = msd_pkg::RAM_WORDS
) (
    input  wire logic                       clk_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       pc_step_i,
    input  wire logic                       pc_load_i,
    input  wire logic [23:0]                pc_target_i,
    output      logic [23:0]                pc_o,
    input  wire msd_pkg::msd_prog_req_type  prog_req_i,
    input  wire logic [23:0]                prog_word_i,
    output      msd_pkg::msd_prog_map_type  prog_map_o,
    input  wire msd_pkg::msd_data_req_type  rd_req_i,
    input  wire msd_pkg::msd_data_req_type  wr_req_i,
    input  wire logic [15:0]                sfr_rdata_i,
    input  wire logic                       sfr_hit_i,
    input  wire logic [15:0]                psv_rdata_i,
    output      msd_pkg::msd_lookup_type    sfr_rd_o,
    output      msd_pkg::msd_lookup_type    psv_rd_o,
    output      msd_pkg::msd_sfr_wr_type    sfr_wr_o,
    output      msd_pkg::msd_word_type      rd_o,
    output      logic                       addr_trap_o,
    input  wire msd_pkg::msd_wreg_req_type  wreg_req_i,
    output      msd_pkg::msd_word_type      wreg_o,
    input  wire msd_pkg::msd_direct_req_type direct_req_i,
    output      msd_pkg::msd_lookup_type    direct_ea_o
);

    localparam int IDX_W = $clog2(RAM_WORDS);
    localparam logic [16:0] RAM_LIMIT =
        17'(msd_pkg::RAM_BASE) + 17'(2 * RAM_WORDS);

    // ==========================================================
    // state
    typedef enum logic [1:0] {
        SRC_NONE, SRC_RAM, SRC_SFR, SRC_PSV
    } msd_src_type;

    typedef struct packed {
        logic        valid;
        logic        byte_op;
        logic        odd;
        msd_src_type src;
        logic [IDX_W-1:0] idx;
    } msd_stage_type;

    typedef struct packed {
        logic [23:0]                 pc;
        msd_pkg::msd_prog_map_type   prog_map;
        msd_stage_type               stage;
        msd_pkg::msd_lookup_type     sfr_rd;
        msd_pkg::msd_lookup_type     psv_rd;
        msd_pkg::msd_sfr_wr_type     sfr_wr;
        msd_pkg::msd_word_type       rd;
        logic                        trap;
        msd_pkg::msd_word_type       wreg;
        msd_pkg::msd_lookup_type     direct_ea;
    } msd_state_type;

    msd_state_type state_q;
    msd_state_type state_d;

    logic [15:0] ram_q [RAM_WORDS];
    logic [15:0] ram_word;
    logic        ram_we_lo;
    logic        ram_we_hi;
    logic [IDX_W-1:0] ram_wr_idx;
    logic [15:0] ram_wr_data;

    // ==========================================================
    // configuration word match, one comparator per entry
    logic [msd_pkg::CFG_COUNT-1:0] cfg_match;

    genvar g;
    generate
        for (g = 0; g < msd_pkg::CFG_COUNT; g++) begin : g_cfg
            assign cfg_match[g] = (prog_req_i.addr ==
                msd_pkg::CFG_ADDRS[g*24 +: 24]);
        end
    endgenerate

    // ==========================================================
    // helpers
    function automatic logic ram_hit(input logic [15:0] ea);
        ram_hit = (ea >= msd_pkg::RAM_BASE)
               && ({1'b0, ea} < RAM_LIMIT);
    endfunction : ram_hit

    function automatic logic [IDX_W-1:0] ram_index(input logic [15:0] ea);
        logic [15:0] off;
        off = ea - msd_pkg::RAM_BASE;
        ram_index = off[IDX_W:1];
    endfunction : ram_index

    assign ram_word = ram_q[state_q.stage.idx];

    // ==========================================================
    // next state
    always_comb begin
        logic [15:0] word_data;
        logic [15:0] wr_ea;
        logic [15:0] rd_ea;
        logic        wr_mis;
        logic        rd_mis;
        logic [15:0] rv;
        logic [23:0] pa;
        word_data   = 16'h0000;
        wr_ea       = wr_req_i.ea;
        rd_ea       = rd_req_i.ea;
        rv          = wreg_req_i.reg_value;
        pa          = prog_req_i.addr;
        wr_mis      = wr_req_i.valid && !wr_req_i.byte_op && wr_ea[0];
        rd_mis      = rd_req_i.valid && !rd_req_i.byte_op && rd_ea[0];
        state_d     = state_q;
        ram_we_lo   = 1'b0;
        ram_we_hi   = 1'b0;
        ram_wr_idx  = ram_index(wr_ea);
        ram_wr_data = wr_req_i.data;

        // program counter
        if (pc_load_i) begin
            state_d.pc = {pc_target_i[23:1], 1'b0};
        end else if (pc_step_i) begin
            state_d.pc = state_q.pc + msd_pkg::PC_STEP;
        end

        // program space classification
        state_d.prog_map.valid = prog_req_i.valid;
        state_d.prog_map.upper_word = pa[0];
        state_d.prog_map.vector = pa < msd_pkg::VECTOR_END;
        state_d.prog_map.ivt_primary = (pa >= msd_pkg::IVT_PRI_LO)
            && (pa <= msd_pkg::IVT_PRI_HI);
        state_d.prog_map.ivt_alternate = (pa >= msd_pkg::IVT_ALT_LO)
            && (pa <= msd_pkg::IVT_ALT_HI);
        state_d.prog_map.eeprom = (pa >= msd_pkg::EEPROM_LO)
            && (pa <= msd_pkg::EEPROM_HI);
        state_d.prog_map.eeprom_index = pa[8:1];
        state_d.prog_map.cfg_sel = cfg_match;
        if (pa[0]) begin
            state_d.prog_map.rdata = {8'h00, prog_word_i[23:16]};
            state_d.prog_map.wr_lanes = {prog_req_i.write, 2'b00};
        end else begin
            state_d.prog_map.rdata = prog_word_i[15:0];
            state_d.prog_map.wr_lanes = {1'b0, {2{prog_req_i.write}}};
        end
        if (!prog_req_i.valid) begin
            state_d.prog_map.wr_lanes = 3'h0;
        end

        // read unit, lookup stage
        state_d.stage.valid   = rd_req_i.valid;
        state_d.stage.byte_op = rd_req_i.byte_op;
        state_d.stage.odd     = rd_ea[0];
        state_d.stage.idx     = ram_index(rd_ea);
        if (rd_ea[msd_pkg::PSV_BIT]) begin
            state_d.stage.src = SRC_PSV;
        end else if (rd_ea <= msd_pkg::SFR_END) begin
            state_d.stage.src = SRC_SFR;
        end else if (ram_hit(rd_ea)) begin
            state_d.stage.src = SRC_RAM;
        end else begin
            state_d.stage.src = SRC_NONE;
        end
        // lookups present the word address; lane chosen in the data stage
        state_d.sfr_rd.valid = rd_req_i.valid
            && !rd_ea[msd_pkg::PSV_BIT] && (rd_ea <= msd_pkg::SFR_END);
        state_d.sfr_rd.ea    = {rd_ea[15:1], 1'b0};
        state_d.psv_rd.valid = rd_req_i.valid && rd_ea[msd_pkg::PSV_BIT];
        state_d.psv_rd.ea    = {rd_ea[15:1], 1'b0};

        // read unit, data stage
        case (state_q.stage.src)
            SRC_RAM: word_data = ram_word;
            SRC_SFR: word_data = sfr_hit_i ? sfr_rdata_i : 16'h0000;
            SRC_PSV: word_data = psv_rdata_i;
            default: word_data = 16'h0000;
        endcase
        state_d.rd.valid = state_q.stage.valid;
        if (state_q.stage.byte_op) begin
            // odd byte address holds the high lane
            state_d.rd.data = state_q.stage.odd ?
                {8'h00, word_data[15:8]} : {8'h00, word_data[7:0]};
        end else begin
            state_d.rd.data = word_data;
        end

        // write unit; misaligned word writes never reach a lane
        state_d.sfr_wr.valid = 1'b0;
        state_d.sfr_wr.ea    = {wr_ea[15:1], 1'b0};
        state_d.sfr_wr.data  = wr_req_i.data;
        state_d.sfr_wr.lane_lo = 1'b0;
        state_d.sfr_wr.lane_hi = 1'b0;
        if (wr_req_i.valid && !wr_mis && !wr_ea[msd_pkg::PSV_BIT]) begin
            if (wr_req_i.byte_op) begin
                // byte sits on low data lane; copy it onto both lanes, the strobes pick its side
                ram_wr_data = {wr_req_i.data[7:0], wr_req_i.data[7:0]};
                state_d.sfr_wr.data = ram_wr_data;
            end
            if (wr_ea <= msd_pkg::SFR_END) begin
                state_d.sfr_wr.valid   = 1'b1;
                state_d.sfr_wr.lane_lo = !wr_req_i.byte_op || !wr_ea[0];
                state_d.sfr_wr.lane_hi = !wr_req_i.byte_op || wr_ea[0];
            end else if (ram_hit(wr_ea)) begin
                ram_we_lo = !wr_req_i.byte_op || !wr_ea[0];
                ram_we_hi = !wr_req_i.byte_op || wr_ea[0];
            end
        end
        // trap follows the access one cycle later, with the write, a cycle before read data
        state_d.trap = rd_mis || wr_mis;

        // work register updates
        state_d.wreg.valid = wreg_req_i.op != msd_pkg::WOP_NONE;
        case (wreg_req_i.op)
            msd_pkg::WOP_POSTINC: begin
                state_d.wreg.data = rv + (wreg_req_i.byte_op ?
                    msd_pkg::BYTE_STEP : msd_pkg::WORD_STEP);
            end
            msd_pkg::WOP_BYTE_LOAD: begin
                state_d.wreg.data = {rv[15:8], wreg_req_i.load_data[7:0]};
            end
            msd_pkg::WOP_ZERO_WIDEN: begin
                state_d.wreg.data = {8'h00, rv[7:0]};
            end
            msd_pkg::WOP_SIGN_WIDEN: begin
                state_d.wreg.data = {{8{rv[7]}}, rv[7:0]};
            end
            default: begin
                state_d.wreg.data = rv;
            end
        endcase

        // direct addressing forms
        state_d.direct_ea.valid = direct_req_i.valid;
        if (direct_req_i.mov_form) begin
            state_d.direct_ea.ea = direct_req_i.field;
        end else begin
            state_d.direct_ea.ea = direct_req_i.field
                & msd_pkg::DIRECT_MASK;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q    <= '0;
            state_q.pc <= msd_pkg::PC_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // data memory; no reset, contents are undefined at power up
    always_ff @(posedge clk_i) begin
        if (ram_we_lo) begin
            ram_q[ram_wr_idx][7:0] <= ram_wr_data[7:0];
        end
        if (ram_we_hi) begin
            ram_q[ram_wr_idx][15:8] <= ram_wr_data[15:8];
        end
    end

    // ==========================================================
    // outputs
    assign pc_o        = state_q.pc;
    assign prog_map_o  = state_q.prog_map;
    assign sfr_rd_o    = state_q.sfr_rd;
    assign psv_rd_o    = state_q.psv_rd;
    assign sfr_wr_o    = state_q.sfr_wr;
    assign rd_o        = state_q.rd;
    assign addr_trap_o = state_q.trap;
    assign wreg_o      = state_q.wreg;
    assign direct_ea_o = state_q.direct_ea;

endmodule : msd_decoder

// >>> verilog/msd_pkg.sv
// msd_pkg: constants and carrier types for the memory space decoder.
// assumes a 16-bit core clocked with the decoder on one clock.
package msd_pkg;

    // ==========================================================
    // program space map
    localparam logic [23:0] PC_RESET       = 24'h000000;
    localparam logic [23:0] PC_STEP        = 24'h000002;
    localparam logic [23:0] VECTOR_END     = 24'h000200;
    localparam logic [23:0] IVT_PRI_LO     = 24'h000004;
    localparam logic [23:0] IVT_PRI_HI     = 24'h0000ff;
    localparam logic [23:0] IVT_ALT_LO     = 24'h000104;
    localparam logic [23:0] IVT_ALT_HI     = 24'h0001ff;
    localparam logic [23:0] EEPROM_LO      = 24'h7ffe00;
    localparam logic [23:0] EEPROM_HI      = 24'h7fffff;
    localparam int          CFG_COUNT      = 8;
    // boot, general, osc select, osc, watchdog, por, debug, deep sleep
    localparam logic [CFG_COUNT*24-1:0] CFG_ADDRS = {
        24'hf80010, 24'hf8000e, 24'hf8000c, 24'hf8000a,
        24'hf80008, 24'hf80006, 24'hf80004, 24'hf80000};

    // ==========================================================
    // data space map
    localparam logic [15:0] SFR_END        = 16'h07ff;
    localparam logic [15:0] RAM_BASE       = 16'h0800;
    localparam int          RAM_WORDS      = 768;
    localparam logic [15:0] DIRECT_MASK    = 16'h1fff;
    localparam logic [15:0] BYTE_STEP      = 16'h0001;
    localparam logic [15:0] WORD_STEP      = 16'h0002;
    localparam int          PSV_BIT        = 15;

    // ==========================================================
    // carrier types
    typedef enum logic [2:0] {
        WOP_NONE, WOP_POSTINC, WOP_BYTE_LOAD, WOP_ZERO_WIDEN, WOP_SIGN_WIDEN
    } msd_wop_type;

    typedef struct packed {
        logic        valid;
        logic        byte_op;
        logic [15:0] ea;
        logic [15:0] data;
    } msd_data_req_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } msd_word_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] ea;
    } msd_lookup_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] ea;
        logic        lane_lo;
        logic        lane_hi;
        logic [15:0] data;
    } msd_sfr_wr_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [23:0] addr;
        logic [15:0] data;
    } msd_prog_req_type;

    typedef struct packed {
        logic        valid;
        logic        upper_word;
        logic        vector;
        logic        ivt_primary;
        logic        ivt_alternate;
        logic        eeprom;
        logic [7:0]  eeprom_index;
        logic [CFG_COUNT-1:0] cfg_sel;
        logic [15:0] rdata;
        logic [2:0]  wr_lanes;
    } msd_prog_map_type;

    typedef struct packed {
        msd_wop_type op;
        logic        byte_op;
        logic [15:0] reg_value;
        logic [15:0] load_data;
    } msd_wreg_req_type;

    typedef struct packed {
        logic        valid;
        logic        mov_form;
        logic [15:0] field;
    } msd_direct_req_type;

endpackage : msd_pkg
